// ---- cfwd_pkg.sv ----
package cfwd_pkg;

  // Register byte offsets inside the 4 KB block window.
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_RELOAD = 12'h004;
  localparam logic [11:0] OFF_TIMER = 12'h008;
  localparam logic [11:0] OFF_COUNTS1 = 12'h010;
  localparam logic [11:0] OFF_COUNTS2 = 12'h014;
  localparam logic [11:0] OFF_FLAGS = 12'h018;
  localparam logic [11:0] OFF_SCRATCH = 12'h01C;
  localparam logic [11:0] OFF_BEGIN = 12'h020;
  localparam logic [11:0] OFF_HALT = 12'h024;
  localparam logic [11:0] OFF_REARM = 12'h028;
  localparam logic [11:0] OFF_ADDV = 12'h02C;
  localparam logic [11:0] OFF_COUNT_PLUS_ONE = 12'h030;
  localparam logic [11:0] OFF_COUNT_PLUS_SIXTEEN = 12'h034;
  localparam logic [11:0] OFF_COUNT_PLUS_TWO_FIFTY_SIX = 12'h038;
  localparam logic [11:0] OFF_SUBV = 12'h03C;
  localparam logic [11:0] OFF_COUNT_MINUS_ONE = 12'h040;
  localparam logic [11:0] OFF_COUNT_MINUS_SIXTEEN = 12'h044;
  localparam logic [11:0] OFF_COUNT_MINUS_TWO_FIFTY_SIX = 12'h048;
  localparam logic [11:0] OFF_LOW16 = 12'h04C;

  // Module state codes; anything else held is a state fault.
  typedef enum logic [3:0] {
    CFWD_IDLE = 4'h5,
    CFWD_ACTIVE = 4'hA
  } cfwd_state_e;

  // Values after reset.
  localparam logic [31:0] RST_CTRL = 32'h5009_2492;
  localparam logic [31:0] RST_RELOAD = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_TIMER = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_CHECK = 32'h0000_0000;
  localparam logic [31:0] RST_SCRATCH = 32'h0000_0000;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [5:0] RST_FAULTS = 6'h00;

  // Control word layout; reserved bits 13:11 and 27:20 keep their reset value, bits 31:28 take the written value.
  localparam logic [31:0] CTRL_KEEP_MASK = 32'h0FF0_3800;
  localparam int POS_RSP_TO = 2;
  localparam int POS_RSP_MIS = 5;
  localparam int POS_RSP_SEQ = 8;
  localparam int POS_RSP_ST = 14;
  localparam int POS_RSP_ADR = 17;
  localparam logic [2:0] RESP_RESET = 3'h1;
  localparam logic [2:0] RESP_IRQ = 3'h2;
  localparam logic [2:0] RESP_NONE = 3'h4;
  localparam logic [1:0] LOCK_ON = 2'h1;
  localparam logic [1:0] LOCK_OFF = 2'h2;

  // Fault indices, equal to the flag bit positions.
  localparam int F_TO = 0;
  localparam int F_MIS = 1;
  localparam int F_SEQ = 2;
  localparam int F_CNT = 3;
  localparam int F_ST = 4;
  localparam int F_ADR = 5;
  localparam int NUM_FAULTS = 6;
  localparam int POS_POR_FLAG = 16;

  // Counter steps and the saturation ceiling of fault counts.
  localparam logic [31:0] STEP_1 = 32'h0000_0001;
  localparam logic [31:0] STEP_16 = 32'h0000_0010;
  localparam logic [31:0] STEP_256 = 32'h0000_0100;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

endpackage

// ---- cfwd_core.sv ----
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module cfwd_core (
  // Clock, clock enable and resets.
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic POR_RST_IN,
  input wire logic CLK_EN_IN,
  // APB slave.
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Fault responses toward the system.
  output logic RESET_REQ_OUT,
  output logic IRQ_OUT
);

  // Decode of the live APB request; selection is purely combinational.
  function automatic logic resp_legal(input logic [2:0] code);
    resp_legal = (code == cfwd_pkg::RESP_RESET) ||
                 (code == cfwd_pkg::RESP_IRQ) ||
                 (code == cfwd_pkg::RESP_NONE);
  endfunction

  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic rst_req_reg;
  logic irq_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] reload_reg;
  logic [31:0] timer_reg;
  logic [31:0] check_reg;
  logic [31:0] scratch_reg;
  logic run_reg;
  logic reload_ok_reg;
  logic por_flag_reg;
  logic [5:0] flags_reg;
  logic [7:0] count_reg [cfwd_pkg::NUM_FAULTS];
  cfwd_pkg::cfwd_state_e state_reg;
  logic state_legal;

  wire any_rst = SYS_RST_IN | POR_RST_IN;
  wire [11:0] addr = PADDR_IN;
  wire access = PSEL_IN & PENABLE_IN & pready_reg & CLK_EN_IN;
  wire wr = access & PWRITE_IN;
  wire sel_ctrl = addr == cfwd_pkg::OFF_CTRL;
  wire sel_reload = addr == cfwd_pkg::OFF_RELOAD;
  wire sel_timer = addr == cfwd_pkg::OFF_TIMER;
  wire sel_cnt1 = addr == cfwd_pkg::OFF_COUNTS1;
  wire sel_cnt2 = addr == cfwd_pkg::OFF_COUNTS2;
  wire sel_flags = addr == cfwd_pkg::OFF_FLAGS;
  wire sel_scratch = addr == cfwd_pkg::OFF_SCRATCH;
  wire sel_begin = addr == cfwd_pkg::OFF_BEGIN;
  wire sel_halt = addr == cfwd_pkg::OFF_HALT;
  wire sel_rearm = addr == cfwd_pkg::OFF_REARM;
  wire sel_addv = addr == cfwd_pkg::OFF_ADDV;
  wire sel_count_plus_one = addr == cfwd_pkg::OFF_COUNT_PLUS_ONE;
  wire sel_count_plus_sixteen = addr == cfwd_pkg::OFF_COUNT_PLUS_SIXTEEN;
  wire sel_count_plus_two_fifty_six = addr == cfwd_pkg::OFF_COUNT_PLUS_TWO_FIFTY_SIX;
  wire sel_subv = addr == cfwd_pkg::OFF_SUBV;
  wire sel_count_minus_one = addr == cfwd_pkg::OFF_COUNT_MINUS_ONE;
  wire sel_count_minus_sixteen = addr == cfwd_pkg::OFF_COUNT_MINUS_SIXTEEN;
  wire sel_count_minus_two_fifty_six = addr == cfwd_pkg::OFF_COUNT_MINUS_TWO_FIFTY_SIX;
  wire sel_low16 = addr == cfwd_pkg::OFF_LOW16;
  wire sel_cmd = sel_begin | sel_halt | sel_rearm | sel_addv | sel_count_plus_one |
                 sel_count_plus_sixteen | sel_count_plus_two_fifty_six | sel_subv | sel_count_minus_one | sel_count_minus_sixteen |
                 sel_count_minus_two_fifty_six | sel_low16;
  wire sel_ro = sel_timer | sel_cnt1 | sel_cnt2;
  wire mapped = sel_ctrl | sel_reload | sel_ro | sel_flags | sel_scratch |
                sel_cmd;
  // Writes to read-only words are refused as well as unmapped accesses.
  wire bad_access = !mapped || (PWRITE_IN && sel_ro);

  // Lock and control-word legality.
  wire locked = ctrl_reg[1:0] == cfwd_pkg::LOCK_ON;
  wire [1:0] new_lock = PWDATA_IN[1:0];
  wire ctrl_word_ok =
    resp_legal(PWDATA_IN[cfwd_pkg::POS_RSP_TO +: 3]) &&
    resp_legal(PWDATA_IN[cfwd_pkg::POS_RSP_MIS +: 3]) &&
    resp_legal(PWDATA_IN[cfwd_pkg::POS_RSP_SEQ +: 3]) &&
    resp_legal(PWDATA_IN[cfwd_pkg::POS_RSP_ST +: 3]) &&
    resp_legal(PWDATA_IN[cfwd_pkg::POS_RSP_ADR +: 3]) &&
    (new_lock == cfwd_pkg::LOCK_ON || new_lock == cfwd_pkg::LOCK_OFF);
  wire ctrl_load = wr && sel_ctrl && !locked && ctrl_word_ok;

  // Command qualification against the module state.
  wire is_idle = state_reg == cfwd_pkg::CFWD_IDLE;
  wire is_active = state_reg == cfwd_pkg::CFWD_ACTIVE;
  wire start_ok = wr && sel_begin && is_idle && reload_ok_reg;
  wire stop_ok = wr && sel_halt && is_active;
  wire rearm_ok = wr && sel_rearm && is_active;
  wire full_match = PWDATA_IN == check_reg;
  wire low_match = PWDATA_IN[15:0] == check_reg[15:0];
  wire rearm_hit = rearm_ok && full_match;
  wire expire = is_active && run_reg && (timer_reg == 32'h0000_0000);

  // Detection events; each sets one flag and bumps one count.
  logic [5:0] fault_ev;
  wire seq_start = wr && sel_begin && !(is_idle && reload_ok_reg);
  wire seq_stop = wr && sel_halt && !is_active;
  wire seq_other = wr && ((sel_rearm && !is_active) ||
                          (sel_reload && !is_idle));
  wire mis_ev = (stop_ok && !full_match) || (rearm_ok && !full_match) ||
                (wr && sel_low16 && !low_match);
  assign fault_ev[cfwd_pkg::F_TO] = expire;
  assign fault_ev[cfwd_pkg::F_MIS] = mis_ev;
  assign fault_ev[cfwd_pkg::F_SEQ] = seq_start | seq_stop | seq_other;
  assign fault_ev[cfwd_pkg::F_CNT] = wr && sel_ctrl && !locked &&
                                     !ctrl_word_ok;
  assign fault_ev[cfwd_pkg::F_ST] = !state_legal;
  assign fault_ev[cfwd_pkg::F_ADR] = access && bad_access;

  always_comb begin
    unique case (state_reg)
      cfwd_pkg::CFWD_IDLE: state_legal = 1'b1;
      cfwd_pkg::CFWD_ACTIVE: state_legal = 1'b1;
      default: state_legal = 1'b0;
    endcase
  end

  wire [31:0] check_next =
    start_ok ? PWDATA_IN :
    (wr && sel_addv) ? check_reg + PWDATA_IN :
    (wr && sel_count_plus_one) ? check_reg + cfwd_pkg::STEP_1 :
    (wr && sel_count_plus_sixteen) ? check_reg + cfwd_pkg::STEP_16 :
    (wr && sel_count_plus_two_fifty_six) ? check_reg + cfwd_pkg::STEP_256 :
    (wr && sel_subv) ? check_reg - PWDATA_IN :
    (wr && sel_count_minus_one) ? check_reg - cfwd_pkg::STEP_1 :
    (wr && sel_count_minus_sixteen) ? check_reg - cfwd_pkg::STEP_16 :
    (wr && sel_count_minus_two_fifty_six) ? check_reg - cfwd_pkg::STEP_256 : check_reg;

  wire [31:0] timer_next = (start_ok || rearm_hit) ? reload_reg :
                           (run_reg && is_active && !expire) ?
                           timer_reg - cfwd_pkg::STEP_1 : timer_reg;
  // stop halts the timer; expiry freezes it so it fires once.
  wire run_next = (start_ok || rearm_hit) ? 1'b1 :
                  (stop_ok || expire || !state_legal) ? 1'b0 : run_reg;
  wire [3:0] state_next = !state_legal ? cfwd_pkg::CFWD_IDLE :
                          start_ok ? cfwd_pkg::CFWD_ACTIVE :
                          stop_ok ? cfwd_pkg::CFWD_IDLE : state_reg;
  wire [31:0] ctrl_next = ctrl_load ?
    ((PWDATA_IN & ~cfwd_pkg::CTRL_KEEP_MASK) |
     (cfwd_pkg::RST_CTRL & cfwd_pkg::CTRL_KEEP_MASK)) : ctrl_reg;

  // Read data; control reads as zero while locked.
  wire [31:0] rd_counts1 = {state_reg, 4'h0,
    count_reg[cfwd_pkg::F_SEQ], count_reg[cfwd_pkg::F_MIS],
    count_reg[cfwd_pkg::F_TO]};
  wire [31:0] rd_counts2 = {8'h00,
    count_reg[cfwd_pkg::F_ADR], count_reg[cfwd_pkg::F_ST],
    count_reg[cfwd_pkg::F_CNT]};
  wire [31:0] rd_flags = {15'h0000, por_flag_reg, 10'h000, flags_reg};
  wire [31:0] rd_mux = (sel_ctrl && !locked) ? ctrl_reg :
                       sel_reload ? reload_reg :
                       sel_timer ? timer_reg :
                       sel_cnt1 ? rd_counts1 :
                       sel_cnt2 ? rd_counts2 :
                       sel_flags ? rd_flags :
                       sel_scratch ? scratch_reg : 32'h0000_0000;

  // Responses per fault; the control fault has no field and always resets.
  logic [2:0] resp [cfwd_pkg::NUM_FAULTS];
  logic [5:0] rst_sel;
  logic [5:0] irq_sel;
  assign resp[cfwd_pkg::F_TO] = ctrl_reg[cfwd_pkg::POS_RSP_TO +: 3];
  assign resp[cfwd_pkg::F_MIS] = ctrl_reg[cfwd_pkg::POS_RSP_MIS +: 3];
  assign resp[cfwd_pkg::F_SEQ] = ctrl_reg[cfwd_pkg::POS_RSP_SEQ +: 3];
  assign resp[cfwd_pkg::F_CNT] = cfwd_pkg::RESP_RESET;
  assign resp[cfwd_pkg::F_ST] = ctrl_reg[cfwd_pkg::POS_RSP_ST +: 3];
  assign resp[cfwd_pkg::F_ADR] = ctrl_reg[cfwd_pkg::POS_RSP_ADR +: 3];

  // Per-fault count and response selection.
  genvar gi;
  generate
    for (gi = 0; gi < cfwd_pkg::NUM_FAULTS; gi++) begin : g_fault
      assign rst_sel[gi] = resp[gi] == cfwd_pkg::RESP_RESET;
      assign irq_sel[gi] = resp[gi] == cfwd_pkg::RESP_IRQ;
      always_ff @(posedge SYS_CLK_IN or posedge POR_RST_IN) begin
        if (POR_RST_IN) begin
          count_reg[gi] <= cfwd_pkg::RST_COUNT;
        end else if (CLK_EN_IN && fault_ev[gi] &&
                     count_reg[gi] != cfwd_pkg::COUNT_MAX) begin
          count_reg[gi] <= count_reg[gi] + 8'h01;
        end
      end
    end
  endgenerate

  // flags set on event; the set wins over a write-one clear.
  wire clr_flags = wr && sel_flags;
  wire [5:0] flags_next = fault_ev |
                          (flags_reg & ~(clr_flags ? PWDATA_IN[5:0] : 6'h00));
  wire por_next = por_flag_reg &
                  !(clr_flags && PWDATA_IN[cfwd_pkg::POS_POR_FLAG]);

  // State reset only by power-on, kept across system reset: flags and scratch word.
  always_ff @(posedge SYS_CLK_IN or posedge POR_RST_IN) begin
    if (POR_RST_IN) begin
      flags_reg <= cfwd_pkg::RST_FAULTS;
      por_flag_reg <= 1'b1;
      scratch_reg <= cfwd_pkg::RST_SCRATCH;
    end else if (CLK_EN_IN) begin
      flags_reg <= flags_next;
      por_flag_reg <= por_next;
      if (wr && sel_scratch) begin
        scratch_reg <= PWDATA_IN;
      end
    end
  end

  // state and control logic return to idle on any reset
  always_ff @(posedge SYS_CLK_IN or posedge any_rst) begin
    if (any_rst) begin
      state_reg <= cfwd_pkg::CFWD_IDLE;
      ctrl_reg <= cfwd_pkg::RST_CTRL;
      reload_reg <= cfwd_pkg::RST_RELOAD;
      timer_reg <= cfwd_pkg::RST_TIMER;
      check_reg <= cfwd_pkg::RST_CHECK;
      run_reg <= 1'b0;
      reload_ok_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      state_reg <= cfwd_pkg::cfwd_state_e'(state_next);
      ctrl_reg <= ctrl_next;
      timer_reg <= timer_next;
      check_reg <= check_next;
      run_reg <= run_next;
      if (wr && sel_reload && is_idle) begin
        reload_reg <= PWDATA_IN;
        reload_ok_reg <= 1'b1;
      end else if (start_ok) begin
        reload_ok_reg <= 1'b0;
      end
    end
  end

  // APB answers one cycle into the access phase, so every access is three
  // cycles long; registering the answer keeps all outputs on flip-flops.
  always_ff @(posedge SYS_CLK_IN or posedge any_rst) begin
    if (any_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      rst_req_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      pready_reg <= PSEL_IN && PENABLE_IN && !pready_reg;
      if (PSEL_IN && PENABLE_IN && !pready_reg) begin
        pslverr_reg <= bad_access;
        prdata_reg <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr_reg <= 1'b0;
      end
      rst_req_reg <= |(flags_reg & rst_sel);
      irq_reg <= |(flags_reg & irq_sel);
    end
  end

  assign PREADY_OUT = pready_reg;
  assign PSLVERR_OUT = pslverr_reg;
  assign PRDATA_OUT = prdata_reg;
  assign RESET_REQ_OUT = rst_req_reg;
  assign IRQ_OUT = irq_reg;

  // Checks that tie each behaviour to its cause.
  sequence s_good_start;
    start_ok && CLK_EN_IN;
  endsequence

  sequence s_active_loaded;
    (state_reg == cfwd_pkg::CFWD_ACTIVE) && run_reg;
  endsequence

  property p_state_legal;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      state_reg == cfwd_pkg::CFWD_IDLE ||
      state_reg == cfwd_pkg::CFWD_ACTIVE;
  endproperty
  a_state_legal: assert property (p_state_legal)
    else $error("module state code left the legal set");

  property p_start_loads;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      s_good_start |=> s_active_loaded ##0
      (check_reg == $past(PWDATA_IN)) && (timer_reg == $past(reload_reg));
  endproperty
  a_start_loads: assert property (p_start_loads)
    else $error("start did not load counter, timer and state");

  property p_start_bad;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      (seq_start && CLK_EN_IN) |=> flags_reg[cfwd_pkg::F_SEQ] &&
      $stable(state_reg);
  endproperty
  a_start_bad: assert property (p_start_bad)
    else $error("misplaced start did not raise a sequence fault");

  property p_stop_bad;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      (seq_stop && CLK_EN_IN) |=> flags_reg[cfwd_pkg::F_SEQ];
  endproperty
  a_stop_bad: assert property (p_stop_bad)
    else $error("stop outside active did not raise a sequence fault");

  property p_stop_halts;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      (stop_ok && CLK_EN_IN) |=> !run_reg ##1 $stable(timer_reg);
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("timer kept running after stop");

  property p_rearm_reload;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      (rearm_hit && CLK_EN_IN) |=> timer_reg == $past(reload_reg);
  endproperty
  a_rearm_reload: assert property (p_rearm_reload)
    else $error("matching rearm did not reload the timer");

  property p_mismatch;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      (rearm_ok && !full_match && CLK_EN_IN) |=>
      flags_reg[cfwd_pkg::F_MIS] && timer_reg != $past(reload_reg) ||
      flags_reg[cfwd_pkg::F_MIS] && $past(timer_reg) == $past(reload_reg);
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("mismatching rearm not flagged or timer reloaded");

  property p_count_plus_sixteen;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      (wr && sel_count_plus_sixteen) |=> check_reg == $past(check_reg) + 32'h0000_0010;
  endproperty
  a_count_plus_sixteen: assert property (p_count_plus_sixteen)
    else $error("add sixteen gave the wrong counter value");

  property p_count_once;
    @(posedge SYS_CLK_IN) disable iff (POR_RST_IN)
      (fault_ev[cfwd_pkg::F_TO] && CLK_EN_IN &&
       count_reg[cfwd_pkg::F_TO] != 8'hFF) |=>
      count_reg[cfwd_pkg::F_TO] == $past(count_reg[cfwd_pkg::F_TO]) + 8'h01;
  endproperty
  a_count_once: assert property (p_count_once)
    else $error("expiry count did not step by exactly one");

  property p_locked_ctrl;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      (locked && wr && sel_ctrl) |=> $stable(ctrl_reg) && locked;
  endproperty
  a_locked_ctrl: assert property (p_locked_ctrl)
    else $error("locked control word changed");

  property p_irq_follow;
    @(posedge SYS_CLK_IN) disable iff (any_rst)
      (CLK_EN_IN && |(flags_reg & irq_sel)) |=> IRQ_OUT;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("flag with interrupt response did not raise the request");

endmodule

// ---- cfwd_core_bench.sv ----
`timescale 1ns/100ps
module cfwd_core_bench;
  // Stimulus toward the block; all of it changes right after rising edges.
  logic sys_clk, sys_rst, por_rst, clk_en;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  // Responses from the block.
  wire [31:0] prdata;
  wire pready, pslverr, reset_req, irq;
  // Bench bookkeeping.
  int errors, comparisons, cycles;
  logic [31:0] rdat, keep;
  logic rerr;

  cfwd_core dut_u (
    .SYS_CLK_IN(sys_clk), .SYS_RST_IN(sys_rst), .POR_RST_IN(por_rst),
    .CLK_EN_IN(clk_en), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .RESET_REQ_OUT(reset_req), .IRQ_OUT(irq)
  );

  // A 40 ns clock.
  always #20 sys_clk = ~sys_clk;

  // The tests need about 1600 cycles; a hang is cut off well beyond that.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      test_done();
    end
  end

  // Prints the counts and the verdict, then stops the run.
  task test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Compares one word and counts the outcome.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle follows so psel is never re-driven
  // in the time step that released it.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h0, 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  // Values seen right after power-on, and clearing of the power-on flag.
  task test_por();
    rdchk(12'h018, 32'h0001_0000);
    rdchk(12'h010, 32'h5000_0000);
    rdchk(12'h014, 32'h0000_0000);
    rdchk(12'h01C, 32'h0000_0000);
    rdchk(12'h000, 32'h5009_2492);
    wr(12'h018, 32'h0001_0000);
    rdchk(12'h018, 32'h0000_0000);
  endtask

  // Sequence faults routed to the interrupt, mismatch to the reset.
  task test_sequence();
    wr(12'h000, 32'h5009_2232);
    rdchk(12'h000, 32'h5009_2232);
    wr(12'h020, 32'h0000_0001);
    rdchk(12'h018, 32'h0000_0004);
    chk({30'h0, irq, reset_req}, 32'h2);
    wr(12'h024, 32'h0000_0000);
    rdchk(12'h010, 32'h5002_0000);
    wr(12'h018, 32'h0000_003F);
    // The request output follows the cleared flag one edge later.
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  // Counter arithmetic, compares, rearm and stop.
  task test_counter();
    wr(12'h004, 32'h0000_0100);
    wr(12'h020, 32'h0000_1000);
    rdchk(12'h010, 32'hA002_0000);
    wr(12'h02C, 32'h0000_0022);
    wr(12'h030, 32'hFFFF_FFFF);
    wr(12'h034, 32'hFFFF_FFFF);
    wr(12'h038, 32'hFFFF_FFFF);
    wr(12'h03C, 32'h0000_0003);
    wr(12'h040, 32'hFFFF_FFFF);
    wr(12'h044, 32'hFFFF_FFFF);
    wr(12'h048, 32'hFFFF_FFFF);
    wr(12'h04C, 32'hABCD_101F);
    rdchk(12'h018, 32'h0000_0000);
    wr(12'h028, 32'h0000_101F);
    xfer(1'b0, 12'h008, 32'h0);
    chk({31'h0, rdat <= 32'h100 && rdat > 32'hE0}, 32'h1);
    wr(12'h028, 32'h0000_0001);
    rdchk(12'h018, 32'h0000_0002);
    chk({31'h0, reset_req}, 32'h1);
    rdchk(12'h010, 32'hA002_0100);
    wr(12'h024, 32'h0000_101F);
    xfer(1'b0, 12'h008, 32'h0);
    keep = rdat;
    rdchk(12'h008, keep);
    rdchk(12'h018, 32'h0000_0002);
    rdchk(12'h010, 32'h5002_0100);
    wr(12'h018, 32'h0000_003F);
    @(posedge sys_clk);
    chk({31'h0, reset_req}, 32'h0);
  endtask

  // An expiring timer flags one timeout and stops at zero.
  task test_expiry();
    wr(12'h004, 32'h0000_0020);
    wr(12'h020, 32'h0000_0000);
    repeat (60) @(posedge sys_clk);
    rdchk(12'h018, 32'h0000_0001);
    rdchk(12'h010, 32'hA002_0101);
    rdchk(12'h008, 32'h0000_0000);
    wr(12'h024, 32'h0000_0000);
    wr(12'h018, 32'h0000_003F);
  endtask

  // Unmapped access and an illegal response code.
  task test_faults();
    xfer(1'b0, 12'h050, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(12'h000, 32'h5009_2332);
    rdchk(12'h018, 32'h0000_0028);
    chk({31'h0, reset_req}, 32'h1);
    rdchk(12'h014, 32'h0001_0001);
    wr(12'h018, 32'h0000_003F);
  endtask

  // Lock, then a system reset that must keep flags, counts and scratch.
  task test_sysreset();
    wr(12'h01C, 32'hA5A5_5A5A);
    wr(12'h000, 32'h5009_2491);
    rdchk(12'h000, 32'h0000_0000);
    wr(12'h000, 32'h5009_2492);
    rdchk(12'h000, 32'h0000_0000);
    // A second start while active faults and keeps the active state.
    wr(12'h004, 32'h0000_0100);
    wr(12'h020, 32'h0000_0000);
    wr(12'h020, 32'h0000_0000);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(12'h018, 32'h0000_0004);
    rdchk(12'h01C, 32'hA5A5_5A5A);
    rdchk(12'h000, 32'h5009_2492);
    rdchk(12'h010, 32'h5003_0101);
  endtask

  // A low clock enable freezes the running timer for ten cycles, so two
  // reads around the pause differ by the four enabled edges only.
  task test_freeze();
    wr(12'h004, 32'h0000_0100);
    wr(12'h020, 32'h0000_0000);
    xfer(1'b0, 12'h008, 32'h0);
    keep = rdat;
    clk_en <= 1'b0;
    repeat (10) @(posedge sys_clk);
    clk_en <= 1'b1;
    rdchk(12'h008, keep - 32'h0000_0004);
    wr(12'h024, 32'h0000_0000);
    rdchk(12'h010, 32'h5003_0101);
  endtask

  // Enough unmapped reads to drive the address count up to its ceiling, where it holds.
  task test_saturate();
    repeat (300) xfer(1'b0, 12'h050, 32'h0);
    rdchk(12'h014, 32'h00FF_0001);
  endtask

  // Power-on reset held for 12 cycles, then the tests in turn.
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b0;
    por_rst = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    por_rst <= 1'b0;
    @(posedge sys_clk);
    test_por();
    test_sequence();
    test_counter();
    test_expiry();
    test_faults();
    test_sysreset();
    test_freeze();
    test_saturate();
    test_done();
  end
endmodule
